/* File: verilog/ssv_pkg.sv */
package ssv_pkg;
   localparam int CLK_NS = 10;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_STATE = 8'h08;
   // Control register fields
   localparam int C_UV_HS = 0;
   localparam int C_UV_LS = 1;
   localparam int C_OV_HS = 2;
   localparam int C_OV_LS = 3;
   localparam int C_THR = 4;
   localparam int C_SEC_EN = 6;
   localparam int C_CAN_EN = 7;
   localparam logic [7:0] CTRL_RST = 8'hCF;
   // Status flag positions
   localparam int F_PWRLOSS = 0;
   localparam int F_MLOW = 1;
   localparam int F_MHIGH = 2;
   localparam int F_PFAIL = 3;
   localparam int F_SFAIL = 4;
   localparam int F_SSHORT = 5;
   localparam int F_CANFAIL = 6;
   localparam int F_THERM = 7;
   localparam int NFLAG = 8;
   localparam int S_CANLOW = 8;
   localparam logic [7:0] FLAG_RST = 8'h01;
   // Operating modes of the chip
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_STANDBY = 2'h1;
   localparam logic [1:0] MODE_SLEEP = 2'h2;
   // Times and derived cycle counts
   localparam int PGL_NS = 5000;
   localparam int RES_NS = 16000;
   localparam int SGL_NS = 2000;
   localparam int PGL_CYC = (PGL_NS + CLK_NS - 1) / CLK_NS;
   localparam int RES_CYC = (RES_NS + CLK_NS - 1) / CLK_NS;
   localparam int SGL_CYC = (SGL_NS + CLK_NS - 1) / CLK_NS;
   localparam int START_MS = 4;
   localparam int THOFF_MS = 1000;
   localparam int START_CYC = START_MS * (1000000 / CLK_NS);
   localparam int THOFF_CYC = THOFF_MS * (1000000 / CLK_NS);
   localparam int THERM_REPEAT = 3;
   // Timer indices
   localparam int T_PGL = 0;
   localparam int T_PST = 1;
   localparam int T_RES = 2;
   localparam int T_SGL = 3;
   localparam int T_SSH = 4;
   localparam int T_THM = 5;
   localparam int NTMR = 6;

   typedef enum logic [3:0] {
      ST_START = 4'b0001,
      ST_RUN = 4'b0010,
      ST_THERM = 4'b0100,
      ST_SLEEP = 4'b1000
   } ssv_state_t;

   typedef struct packed {
      logic main_low;
      logic main_high;
      logic prim_low;
      logic [3:0] prim_res_low;
      logic sec_low;
      logic can_low;
      logic therm1;
      logic therm2;
      logic load_low;
      logic load_high;
   } ssv_cmp_t;
   // Primary reads as failed until the synchroniser has flushed
   localparam ssv_cmp_t CMP_RST = 13'h0400;

   typedef struct packed {
      logic reset_out_n;
      logic primary_en;
      logic secondary_en;
      logic hs_off;
      logic ls_off;
      logic lin_tx_dis;
      logic can_from_dedicated;
      logic can_dis;
      logic wd_en;
      logic force_sleep;
   } ssv_out_t;
endpackage

/* File: verilog/ssv_supervisor.sv */
`timescale 1ns/1ps
// Functional notes
// [R1] Hold defaults under POR, then power-up state
// [R2] Power-on sets latched power_loss_flag
// [R3] Undervoltage: drivers off per config, LIN off
// [R4] Overvoltage: drivers off per config, flag
// [R5] Second thermal level: primary off one second
// [R6] Recurring thermal shutdowns force sleep mode
// [R7] Primary startup timeout: fail flag, sleep
// [R8] Primary dip past glitch time sets flag
// [R9] Four selectable primary reset thresholds
// [R10] Filtered low primary asserts reset_out_n
// [R11] Loads off until reset released, watchdog served
// [R12] Standby: watchdog off only below low current
// [R13] Standby: watchdog back on above upper current
// [R14] First thermal level disables all load drivers
// [R15] Secondary monitored in normal and cyclic modes
// [R16] Secondary glitch sets fail flag, keeps running
// [R17] Secondary short timeout disables, sets two flags
// [R18] Both flags cleared before secondary re-enable
// [R19] CAN supply: dedicated in normal, else main
// [R20] CAN low status unlatched in normal mode
// [R21] CAN undervoltage latched, transceiver disabled
// [R22] Flags cleared only by status read-and-clear
// [R23] Filters and timeouts are restartable counters
// [R24] Event in clear cycle keeps flag set
module ssv_supervisor
   import ssv_pkg::*;
#(
   parameter int START_CYCLES = START_CYC,
   parameter int THERM_OFF_CYCLES = THOFF_CYC
) (
   // Clock and main-supply power-on reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog comparators and chip context
   input wire ssv_cmp_t cmp,
   input wire logic [1:0] op_mode,
   input wire logic wd_served,
   input wire logic wake,
   // Supply controls
   output ssv_out_t ctl,
   output logic [1:0] reset_thr_sel
);
   ssv_cmp_t meta_q, syn_q;
   ssv_state_t state_q, state_d;
   ssv_out_t out_q, out_d;
   logic [7:0] ctrl_q;
   logic [NFLAG-1:0] flag_q, flag_d, set_w, clr_w;
   logic [31:0] tcnt_q [NTMR];
   logic [NTMR-1:0] tcond, texp;
   logic [1:0] therm_cnt_q;
   logic therm2_q, sec_lock_q, load_hold_q, wd_en_q, rst_low_q;
   logic awv_q, wv_q, bvalid_q, rvalid_q, berr_q, rerr_q;
   logic [7:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic [31:0] rdata_q;

   function automatic logic mapped(input logic [7:0] a);
      return a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_STATE;
   endfunction

   // Comparators are asynchronous to aclk
   // Reset to a failed primary so START cannot pass on a stale good reading
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= CMP_RST;
         syn_q <= CMP_RST;
      end else begin
         meta_q <= cmp;
         syn_q <= meta_q;
      end
   end

   wire mode_normal = op_mode == MODE_NORMAL;
   wire mode_standby = op_mode == MODE_STANDBY;
   wire in_run = state_q == ST_RUN;
   wire sec_mon = ctl.secondary_en && !(op_mode == MODE_SLEEP && !wake); // see [R15]
   wire res_low = syn_q.prim_res_low[ctrl_q[C_THR+:2]]; // see [R9]

   assign tcond[T_PGL] = in_run && syn_q.prim_low;
   assign tcond[T_PST] = state_q == ST_START && syn_q.prim_low;
   assign tcond[T_RES] = in_run && res_low;
   assign tcond[T_SGL] = sec_mon && syn_q.sec_low;
   assign tcond[T_SSH] = sec_mon && syn_q.sec_low;
   assign tcond[T_THM] = state_q == ST_THERM;

   // Each counter restarts when its condition drops and saturates at its limit
   generate
      for (genvar i = 0; i < NTMR; i++) begin : g_tmr
         localparam int LIM = i == T_PGL ? PGL_CYC : i == T_PST ? START_CYCLES :
                              i == T_RES ? RES_CYC : i == T_SGL ? SGL_CYC :
                              i == T_SSH ? START_CYCLES : THERM_OFF_CYCLES;
         assign texp[i] = tcond[i] && tcnt_q[i] == 32'(LIM - 1);
         always_ff @(posedge aclk) begin
            if (!aresetn || !tcond[i]) begin
               tcnt_q[i] <= '0; // see [R23]
            end else if (tcnt_q[i] != 32'(LIM)) begin
               tcnt_q[i] <= tcnt_q[i] + 32'h1;
            end
         end
      end
   endgenerate

   wire therm2_rise = syn_q.therm2 && !therm2_q;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_START: begin
            if (texp[T_PST]) begin
               state_d = ST_SLEEP; // see [R7]
            end else if (!syn_q.prim_low) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (therm2_rise) begin
               state_d = therm_cnt_q == 2'(THERM_REPEAT - 1) ? ST_SLEEP : ST_THERM; // see [R5] [R6]
            end
         end
         ST_THERM: begin
            if (texp[T_THM]) begin
               state_d = ST_START; // see [R5]
            end
         end
         ST_SLEEP: begin
            if (wake) begin
               state_d = ST_START;
            end
         end
         default: state_d = ST_START;
      endcase
   end

   // Hardware set wins over the read-and-clear
   assign set_w[F_PWRLOSS] = 1'b0;
   assign set_w[F_MLOW] = syn_q.main_low; // see [R3]
   assign set_w[F_MHIGH] = syn_q.main_high; // see [R4]
   assign set_w[F_PFAIL] = texp[T_PGL] || texp[T_PST]; // see [R7] [R8]
   assign set_w[F_SFAIL] = texp[T_SGL] || texp[T_SSH]; // see [R16] [R17]
   assign set_w[F_SSHORT] = texp[T_SSH]; // see [R17]
   assign set_w[F_CANFAIL] = mode_normal && ctrl_q[C_CAN_EN] && syn_q.can_low; // see [R21]
   assign set_w[F_THERM] = syn_q.therm1; // see [R14]
   wire rd_hs = s_axi_arvalid && s_axi_arready;
   assign clr_w = rd_hs && s_axi_araddr == ADDR_STAT ? flag_q : '0; // see [R22]
   assign flag_d = (flag_q & ~clr_w) | set_w; // see [R24]

   wire loads_off = load_hold_q || syn_q.therm1; // see [R11] [R14]
   wire prim_on = state_q == ST_START || state_q == ST_RUN;

   always_comb begin
      out_d.reset_out_n = !rst_low_q; // see [R10]
      out_d.primary_en = prim_on; // see [R5]
      out_d.secondary_en = ctrl_q[C_SEC_EN] && !sec_lock_q && !loads_off && prim_on; // see [R18]
      out_d.hs_off = loads_off || (syn_q.main_low && ctrl_q[C_UV_HS]) ||
                     (syn_q.main_high && ctrl_q[C_OV_HS]); // see [R3] [R4]
      out_d.ls_off = loads_off || (syn_q.main_low && ctrl_q[C_UV_LS]) ||
                     (syn_q.main_high && ctrl_q[C_OV_LS]); // see [R3] [R4]
      out_d.lin_tx_dis = syn_q.main_low; // see [R3]
      out_d.can_from_dedicated = mode_normal; // see [R19]
      out_d.can_dis = !ctrl_q[C_CAN_EN] || (mode_normal && syn_q.can_low); // see [R21]
      out_d.wd_en = wd_en_q;
      out_d.force_sleep = state_q == ST_SLEEP; // see [R6] [R7]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_START; // see [R1]
         flag_q <= FLAG_RST; // see [R2]
         out_q <= '0;
         therm2_q <= 1'b0;
         therm_cnt_q <= '0;
         rst_low_q <= 1'b1;
         load_hold_q <= 1'b1;
         sec_lock_q <= 1'b0;
         wd_en_q <= 1'b1;
      end else begin
         state_q <= state_d;
         flag_q <= flag_d;
         out_q <= out_d;
         therm2_q <= syn_q.therm2;
         if (state_d == ST_SLEEP) begin
            therm_cnt_q <= '0;
         end else if (in_run && therm2_rise) begin
            therm_cnt_q <= therm_cnt_q + 2'h1;
         end
         // Reset stays low through power-up until the primary is good
         if (texp[T_RES] || state_q != ST_RUN) begin
            rst_low_q <= 1'b1; // see [R10]
         end else if (!res_low) begin
            rst_low_q <= 1'b0;
         end
         if (rst_low_q) begin
            load_hold_q <= 1'b1; // see [R11]
         end else if (wd_served) begin
            load_hold_q <= 1'b0;
         end
         if (texp[T_SSH]) begin
            sec_lock_q <= 1'b1; // see [R17]
         end else if (!flag_q[F_SFAIL] && !flag_q[F_SSHORT]) begin
            sec_lock_q <= 1'b0; // see [R18]
         end
         if (!mode_standby) begin
            wd_en_q <= op_mode != MODE_SLEEP;
         end else if (syn_q.load_high) begin
            wd_en_q <= 1'b1; // see [R13]
         end else if (syn_q.load_low) begin
            wd_en_q <= 1'b0; // see [R12]
         end
      end
   end

   assign ctl = out_q;
   assign reset_thr_sel = ctrl_q[C_THR+:2]; // see [R9]

   // AXI4-Lite: address and data are taken in either order, response follows both
   assign s_axi_awready = !awv_q && !bvalid_q;
   assign s_axi_wready = !wv_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = berr_q ? 2'h2 : 2'h0;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rerr_q ? 2'h2 : 2'h0;
   wire wr_go = awv_q && wv_q && !bvalid_q;
   wire [31:0] stat_word = {23'h0, mode_normal && syn_q.can_low, flag_q}; // see [R20]
   wire [31:0] state_word = {22'h0, wd_en_q, load_hold_q, sec_lock_q, out_q.reset_out_n,
                             2'h0, state_q};
   wire [31:0] rd_word = s_axi_araddr == ADDR_CTRL ? {24'h0, ctrl_q} :
                         s_axi_araddr == ADDR_STAT ? stat_word :
                         s_axi_araddr == ADDR_STATE ? state_word : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RST; // see [R1]
         awv_q <= 1'b0;
         wv_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         berr_q <= 1'b0;
         rvalid_q <= 1'b0;
         rerr_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awv_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wv_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            awv_q <= 1'b0;
            wv_q <= 1'b0;
            bvalid_q <= 1'b1;
            berr_q <= !mapped(awaddr_q);
            if (awaddr_q == ADDR_CTRL && wstrb0_q) begin
               ctrl_q <= wdata_q; // see [R18]
            end
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_hs) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rerr_q <= !mapped(s_axi_araddr);
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   por_flag_a: assert property (!$past(aresetn) |-> flag_q[F_PWRLOSS]) // see [R2]
      else $error("power loss flag not set after power-on");
   uv_driver_a: assert property (syn_q.main_low && ctrl_q[C_UV_HS] |=> ctl.hs_off && ctl.lin_tx_dis) // see [R3]
      else $error("undervoltage did not force drivers off");
   ov_flag_a: assert property (syn_q.main_high |=> flag_q[F_MHIGH]) // see [R4]
      else $error("overvoltage not flagged");
   therm_off_a: assert property (state_q == ST_THERM |=> !ctl.primary_en) // see [R5]
      else $error("primary on during thermal off time");
   reset_out_a: assert property (texp[T_RES] |=> ##1 !ctl.reset_out_n) // see [R10]
      else $error("reset not asserted after filter time");
   sec_short_a: assert property (texp[T_SSH] |=> flag_q[F_SFAIL] && flag_q[F_SSHORT] ##1 !ctl.secondary_en) // see [R17]
      else $error("secondary short not handled");
   set_wins_a: assert property (set_w != '0 |=> (flag_q & $past(set_w)) == $past(set_w)) // see [R24]
      else $error("flag event lost");
   can_fail_a: assert property (mode_normal && ctrl_q[C_CAN_EN] && syn_q.can_low
                                |=> flag_q[F_CANFAIL] && ctl.can_dis) // see [R21]
      else $error("CAN undervoltage not latched");
   wd_low_a: assert property (mode_standby && syn_q.load_low && !syn_q.load_high |=> ##1 !ctl.wd_en) // see [R12]
      else $error("watchdog not disabled at low load");
   // Outcomes of each supervision path, one edge after the condition, two where a state or enable register sits between
   uv_flag_a: assert property (syn_q.main_low |=> flag_q[F_MLOW]) // see [R3]
      else $error("undervoltage not flagged");
   uv_ls_a: assert property (syn_q.main_low && ctrl_q[C_UV_LS] |=> ctl.ls_off) // see [R3]
      else $error("undervoltage did not force low side off");
   ov_hs_a: assert property (syn_q.main_high && ctrl_q[C_OV_HS] |=> ctl.hs_off) // see [R4]
      else $error("overvoltage did not force high side off");
   start_sleep_a: assert property (texp[T_PST] |=> ##1 ctl.force_sleep) // see [R7]
      else $error("startup timeout did not force sleep");
   prim_fail_a: assert property (texp[T_PGL] |=> flag_q[F_PFAIL]) // see [R8]
      else $error("primary dip not flagged");
   load_hold_a: assert property (load_hold_q |=> !ctl.secondary_en) // see [R11]
      else $error("secondary on while loads held");
   wd_high_a: assert property (mode_standby && syn_q.load_high |=> ##1 ctl.wd_en) // see [R13]
      else $error("watchdog not reactivated at high load");
   therm1_off_a: assert property (syn_q.therm1 |=> !ctl.secondary_en && ctl.hs_off && ctl.ls_off) // see [R14]
      else $error("loads on above first thermal level");
   sec_glitch_a: assert property (texp[T_SGL] |=> flag_q[F_SFAIL]) // see [R16]
      else $error("secondary glitch not flagged");
   sec_lock_a: assert property (sec_lock_q |=> !ctl.secondary_en) // see [R18]
      else $error("secondary enabled before flags cleared");
   can_src_a: assert property (mode_normal |=> ctl.can_from_dedicated) // see [R19]
      else $error("CAN not on dedicated supply in normal mode");
endmodule // ssv_supervisor

/* File: tb/ssv_mcu_model.sv */
`timescale 1ns/1ps
// Host micro: register bus master and watchdog service
module ssv_mcu_model (
   // Clock
   input wire logic aclk,
   // Bus master
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready,
   // Watchdog
   output logic wd_served
);
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready, wd_served} = '0;
   end
   // Handshakes are judged just before the edge that takes them
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic at;
      logic dt;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      do begin
         @(negedge aclk);
         at = awvalid & awready;
         dt = wvalid & wready;
         @(posedge aclk);
         if (at) {awvalid, awaddr} <= {1'b0, ~a};
         if (dt) {wvalid, wdata} <= {1'b0, ~d};
      end while ((awvalid & !at) | (wvalid & !dt));
      do @(negedge aclk); while (!bvalid);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   // A status read is the acknowledge of every latched flag
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      {arvalid, araddr} <= {1'b0, ~a};
      do @(negedge aclk); while (!rvalid);
      {d, r} = {rdata, rresp};
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   task automatic serve;
      @(posedge aclk) wd_served <= 1'b1;
      @(posedge aclk) wd_served <= 1'b0;
   endtask
endmodule // ssv_mcu_model

/* File: tb/ssv_supervisor_tb_top.sv */
`timescale 1ns/1ps
module ssv_supervisor_tb_top;
   import ssv_pkg::*;
   logic aclk = 0, aresetn = 0, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, wd, wake = 0;
   logic [7:0] awa, ara;
   logic [31:0] wda, rda;
   logic [1:0] bre, rre, op_mode = MODE_NORMAL, thr;
   ssv_cmp_t cmp = '0;
   ssv_out_t ctl;
   int fails = 0, num_checks = 0, cycles = 0;
   always #5 aclk = ~aclk;
   ssv_supervisor #(.START_CYCLES(300), .THERM_OFF_CYCLES(40)) ssv_supervisor_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wda), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bre),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rda), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr), .cmp(cmp),
      .op_mode(op_mode), .wd_served(wd), .wake(wake), .ctl(ctl), .reset_thr_sel(thr));
   ssv_mcu_model ssv_mcu_model_inst (
      .aclk(aclk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wda), .wvalid(wv), .wready(wr),
      .bresp(bre), .bvalid(bv), .bready(br), .araddr(ara), .arvalid(arv), .arready(arr), .rdata(rda),
      .rresp(rre), .rvalid(rv), .rready(rr), .wd_served(wd));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chb(input string n, input logic s, input logic e);
      chk(n, {31'h0, s}, {31'h0, e});
   endtask
   // Ends on a falling edge so outputs are settled when compared
   task automatic cy(input int n);
      repeat (n) @(negedge aclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      ssv_mcu_model_inst.rd(a, d, r);
      chk("rdata", d, e);
      chk("rresp", {30'h0, r}, {30'h0, er});
   endtask
   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      ssv_mcu_model_inst.wr(a, d, r);
      chk("bresp", {30'h0, r}, {30'h0, er});
   endtask
   task automatic wrel;
      for (int i = 0; i < 400 && ctl.reset_out_n !== 1'b1; i++) @(negedge aclk);
      chb("reset_out_n", ctl.reset_out_n, 1'b1);
      ssv_mcu_model_inst.serve();
   endtask
   task automatic t_reset;
      wrel();
      rdc(ADDR_CTRL, {24'h0, CTRL_RST}, 2'h0);
      rdc(ADDR_STAT, 32'h1, 2'h0);
      rdc(ADDR_STAT, 32'h0, 2'h0);
      // Running, reset released, loads freed by the service, watchdog on
      rdc(ADDR_STATE, 32'h242, 2'h0);
      rdc(8'h0C, 32'h0, 2'h2);
      wrc(8'h10, 32'h0, 2'h2);
   endtask
   task automatic t_supply;
      @(posedge aclk) cmp.main_low <= 1'b1;
      cy(10);
      chk("uv off", {29'h0, ctl.hs_off, ctl.ls_off, ctl.lin_tx_dis}, 32'h7);
      @(posedge aclk) {cmp.main_low, cmp.main_high} <= 2'b01;
      cy(10);
      chk("ov off", {30'h0, ctl.hs_off, ctl.ls_off}, 32'h3);
      @(posedge aclk) cmp.main_high <= 1'b0;
      // Let the synchroniser clear, or the read-and-clear would re-latch the flag
      cy(5);
      rdc(ADDR_STAT, 32'h6, 2'h0);
   endtask
   task automatic t_prim;
      @(posedge aclk) cmp.prim_low <= 1'b1;
      cy(400);
      @(posedge aclk) cmp.prim_low <= 1'b0;
      rdc(ADDR_STAT, 32'h0, 2'h0);
      @(posedge aclk) cmp.prim_low <= 1'b1;
      cy(520);
      @(posedge aclk) cmp.prim_low <= 1'b0;
      rdc(ADDR_STAT, 32'h8, 2'h0);
   endtask
   task automatic t_thr;
      wrc(ADDR_CTRL, 32'hEF, 2'h0);
      chk("thr", {30'h0, thr}, 32'h2);
      @(posedge aclk) cmp.prim_res_low <= 4'b1000;
      cy(1800);
      chb("reset_out_n", ctl.reset_out_n, 1'b1);
      @(posedge aclk) cmp.prim_res_low <= 4'b1100;
      cy(1500);
      chb("reset_out_n", ctl.reset_out_n, 1'b1);
      cy(200);
      chb("reset_out_n", ctl.reset_out_n, 1'b0);
      @(posedge aclk) cmp.prim_res_low <= 4'b0000;
      for (int i = 0; i < 400 && ctl.reset_out_n !== 1'b1; i++) @(negedge aclk);
      chb("secondary_en", ctl.secondary_en, 1'b0);
      ssv_mcu_model_inst.serve();
      cy(5);
      chb("secondary_en", ctl.secondary_en, 1'b1);
      wrc(ADDR_CTRL, {24'h0, CTRL_RST}, 2'h0);
   endtask
   task automatic t_sec;
      @(posedge aclk) cmp.sec_low <= 1'b1;
      cy(250);
      @(posedge aclk) cmp.sec_low <= 1'b0;
      chb("secondary_en", ctl.secondary_en, 1'b1);
      rdc(ADDR_STAT, 32'h10, 2'h0);
      @(posedge aclk) cmp.sec_low <= 1'b1;
      cy(320);
      chb("secondary_en", ctl.secondary_en, 1'b0);
      @(posedge aclk) cmp.sec_low <= 1'b0;
      cy(10);
      chb("secondary_en", ctl.secondary_en, 1'b0);
      rdc(ADDR_CTRL, {24'h0, CTRL_RST}, 2'h0);
      rdc(ADDR_STAT, 32'h30, 2'h0);
      cy(10);
      chb("secondary_en", ctl.secondary_en, 1'b1);
   endtask
   task automatic t_can;
      @(posedge aclk) cmp.can_low <= 1'b1;
      cy(10);
      chk("can", {30'h0, ctl.can_dis, ctl.can_from_dedicated}, 32'h3);
      rdc(ADDR_STAT, 32'h140, 2'h0);
      @(posedge aclk) cmp.can_low <= 1'b0;
      cy(5);
      // The clear met a still-low supply, so the flag came back
      rdc(ADDR_STAT, 32'h40, 2'h0);
      rdc(ADDR_STAT, 32'h0, 2'h0);
      @(posedge aclk) op_mode <= MODE_STANDBY;
      cy(5);
      chk("stby", {30'h0, ctl.can_from_dedicated, ctl.wd_en}, 32'h1);
      @(posedge aclk) cmp.load_low <= 1'b1;
      cy(5);
      chb("wd_en", ctl.wd_en, 1'b0);
      @(posedge aclk) cmp.load_high <= 1'b1;
      cy(5);
      chb("wd_en", ctl.wd_en, 1'b1);
      @(posedge aclk) op_mode <= MODE_SLEEP;
      cy(5);
      chk("sleep", {30'h0, ctl.can_from_dedicated, ctl.wd_en}, 32'h0);
      @(posedge aclk) {op_mode, cmp.load_low, cmp.load_high} <= {MODE_NORMAL, 2'b00};
   endtask
   task automatic t_therm;
      @(posedge aclk) cmp.therm1 <= 1'b1;
      cy(10);
      chb("secondary_en", ctl.secondary_en, 1'b0);
      @(posedge aclk) cmp.therm1 <= 1'b0;
      rdc(ADDR_STAT, 32'h80, 2'h0);
      for (int i = 0; i < THERM_REPEAT; i++) begin
         @(posedge aclk) cmp.therm2 <= 1'b1;
         cy(10);
         if (i < THERM_REPEAT - 1) begin
            chb("primary_en", ctl.primary_en, 1'b0);
            @(posedge aclk) cmp.therm2 <= 1'b0;
            cy(60);
            chb("primary_en", ctl.primary_en, 1'b1);
         end else begin
            chb("force_sleep", ctl.force_sleep, 1'b1);
            @(posedge aclk) cmp.therm2 <= 1'b0;
         end
      end
      @(posedge aclk) wake <= 1'b1;
      @(posedge aclk) wake <= 1'b0;
      wrel();
      chb("force_sleep", ctl.force_sleep, 1'b0);
   endtask
   task automatic t_start;
      @(posedge aclk) {cmp.prim_low, aresetn} <= 2'b10;
      cy(6);
      @(posedge aclk) aresetn <= 1'b1;
      cy(330);
      chb("force_sleep", ctl.force_sleep, 1'b1);
      rdc(ADDR_STAT, 32'h9, 2'h0);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_supply();
      t_prim();
      t_thr();
      t_sec();
      t_can();
      t_therm();
      t_start();
      stop_test();
   end
endmodule // ssv_supervisor_tb_top
